// ### rtl/acpi_wake_power_loss_ctrl.sv
// Wake-up key storage, wake event status, power-loss policy and reset source selection
//
// The Avalon-MM slave port was decided locally.
`include "acpi_wake_consts.svh"

module acpi_wake_power_loss_ctrl #(
    parameter int PULSE_CYCLES = `POWER_BUTTON_OUT_N_PULSE_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        kbd_key_valid_i,
    input  wire logic [7:0]  kbd_key_i,
    input  wire logic        mouse_wake_evt_i,
    input  wire logic        thermal_evt_i,
    input  wire logic        power_button_in_n_i,
    input  wire logic        standby_supply_ok_i,
    input  wire logic        sleep_s1_i,
    input  wire logic        sleep_s3_n_i,
    input  wire logic        sleep_s5_i,
    input  wire logic        supply_on_n_i,
    input  wire logic        supply_good_in_i,
    input  wire logic        resume_reset_n_i,
    input  wire logic        bus_reset_n_i,
    output logic             standby_gate_out_n_o,
    output logic             power_button_out_n_o,
    output logic             power_good_out_o,
    output logic             resume_power_on_o,
    output logic             gpio_group_a_rst_o,
    output logic             gpio_group9_rst_o,
    output logic             gpio_group8_rst_o,
    output logic             gpio_group7_rst_o
);

    localparam int NSYNC = 10;
    // Idle pin levels, so no false edge follows reset: resets off, button up, supplies good
    localparam logic [NSYNC-1:0] SYNC_RST = 10'h396;
    // Storage slot of a wake index: {valid, set, low nibble}; 0F/1F/3F/4F are holes
    function automatic logic [6:0] key_slot(input logic [7:0] idx);
        logic       ok;
        logic [1:0] set;
        ok  = (idx[3:0] != 4'hf);
        set = 2'h0;
        case (idx[7:4])
            4'h0: set = 2'h0;
            4'h1: set = 2'h1;
            4'h3: set = 2'h2;
            4'h4: set = 2'h3;
            default: ok = 1'b0;
        endcase
        return {ok, set, idx[3:0]};
    endfunction : key_slot

    acpi_wake_pkg::bus_state_e bus_reg, bus_next;
    logic [31:0]               readdata_reg;
    logic                      waitrequest_reg;
    logic [7:0]                index_reg;
    logic [7:0]                status_reg, status_next;
    logic [7:0]                ctrl_reg, ctrl_next;
    logic [7:0]                grs_reg;
    logic [7:0]                wen_reg;
    logic [7:0]                last_reg;
    acpi_wake_pkg::key_byte_t  key_mem [0:63];
    logic [3:0]                cap_ptr_reg;
    logic [3:0]                match_ptr_reg, match_ptr_next;
    logic [NSYNC-1:0]          sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_d_reg;
    logic                      was_on_reg;
    logic [7:0]                pulse_cnt_reg;
    logic                      gate_n_reg, power_button_out_n_n_reg, pg_reg, resume_on_reg;
    logic [3:0]                gpio_rst_reg;

    // Pin inputs, five flops each: three sync flops, a two-sample agreement filter and an edge-detect delay
    wire [NSYNC-1:0] pins = {bus_reset_n_i, resume_reset_n_i, supply_good_in_i,
                             supply_on_n_i, sleep_s5_i, sleep_s3_n_i, sleep_s1_i,
                             standby_supply_ok_i, power_button_in_n_i, thermal_evt_i};
    wire thermal_f  = filt_reg[0];
    wire power_button_in_n_f   = filt_reg[1];
    wire standby_f  = filt_reg[2];
    wire s1_f       = filt_reg[3];
    wire s3_n_f     = filt_reg[4];
    wire s5_f       = filt_reg[5];
    wire son_n_f    = filt_reg[6];
    wire sgood_f    = filt_reg[7];
    wire rsm_rst    = ~filt_reg[8];
    wire bus_rst    = ~filt_reg[9];
    wire pg_rst     = ~pg_reg;
    wire [NSYNC-1:0] agree = ~(sync2_reg ^ sync3_reg);

    wire thermal_rise = thermal_f & ~filt_d_reg[0];
    wire power_button_in_fall    = ~power_button_in_n_f & filt_d_reg[1];
    wire standby_rise = standby_f & ~filt_d_reg[2];
    // Bus decode
    wire bus_req   = read_i | write_i;
    wire acc       = (bus_reg == acpi_wake_pkg::BUS_ACK);
    wire wr_acc    = acc & write_i & byteenable_i[0];
    wire rd_acc    = acc & read_i;
    wire [7:0] wb  = writedata_i[7:0];
    wire wr_wen    = wr_acc & (address_i == `IDX_WAKE_ENABLE);
    wire wr_index  = wr_acc & (address_i == `IDX_KBD_WAKE_INDEX);
    wire wr_data   = wr_acc & (address_i == `IDX_KBD_WAKE_DATA);
    wire wr_ctrl   = wr_acc & (address_i == `IDX_POWER_LOSS_CTRL);
    wire wr_grs    = wr_acc & (address_i == `IDX_GPIO_RST_SOURCE);
    wire wr_last   = wr_acc & (address_i == `IDX_LAST_STATE);
    wire rd_status = rd_acc & (address_i == `IDX_WAKE_EVT_STATUS);

    wire [6:0] bus_slot = key_slot(index_reg);
    wire [7:0] data_rd  = bus_slot[6] ? key_mem[bus_slot[5:0]] : 8'h00;

    logic [7:0] rd_byte;
    always_comb begin
        case (address_i)
            `IDX_WAKE_ENABLE:     rd_byte = wen_reg;
            `IDX_KBD_WAKE_INDEX:  rd_byte = index_reg;
            `IDX_KBD_WAKE_DATA:   rd_byte = data_rd;
            `IDX_WAKE_EVT_STATUS: rd_byte = status_reg;
            `IDX_POWER_LOSS_CTRL: rd_byte = ctrl_reg;
            `IDX_GPIO_RST_SOURCE: rd_byte = grs_reg;
            `IDX_LAST_STATE:      rd_byte = last_reg;
            default:              rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        case (bus_reg)
            acpi_wake_pkg::BUS_IDLE: bus_next = bus_req ? acpi_wake_pkg::BUS_ACK
                                                        : acpi_wake_pkg::BUS_IDLE;
            default:                 bus_next = acpi_wake_pkg::BUS_IDLE;
        endcase
    end
    // Keyboard wake: sequence match on the first key set, or any character
    wire        any_key   = wen_reg[`WEN_ANY_CHAR] | ctrl_reg[`PLC_KBD_ANY];
    wire [6:0]  m_slot    = key_slot({4'h0, match_ptr_reg});
    wire [6:0]  m_slot_nx = key_slot({4'h0, match_ptr_reg + 4'h1});
    wire        m_hit     = (kbd_key_i == key_mem[m_slot[5:0]]);
    wire        m_last    = (match_ptr_reg == `KEY_SLOTS - 4'h1)
                            | (key_mem[m_slot_nx[5:0]] == 8'h00);
    wire        kbd_wake  = kbd_key_valid_i & wen_reg[`WEN_KBD]
                            & (any_key | (m_hit & m_last));
    wire        ms_wake   = mouse_wake_evt_i & wen_reg[`WEN_MOUSE];
    wire        any_wake  = kbd_wake | ms_wake;
    wire [6:0]  c_slot    = key_slot(`CAPTURE_BASE + {4'h0, cap_ptr_reg});

    assign match_ptr_next = !kbd_key_valid_i              ? match_ptr_reg
                          : (any_key || !m_hit || m_last) ? 4'h0
                          :                                 match_ptr_reg + 4'h1;

    // Set wins over read-clear; only bits that were reported are cleared
    wire [7:0] sts_clr = rd_status ? readdata_reg[7:0] : 8'h00;
    wire [7:0] sts_set = {3'h0, standby_rise, thermal_rise, power_button_in_fall,
                          ms_wake, kbd_wake};
    assign status_next = ((status_reg & ~sts_clr) | sts_set) & `STS_MASK;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = wb & `PLC_MASK;
        end
        if (ctrl_reg[`PLC_HUNT] && any_wake) begin
            ctrl_next[`PLC_HUNT] = 1'b0;
        end
        if (pg_rst) begin
            ctrl_next[`PLC_GATE_EN] = 1'b0;
        end
        if (bus_rst) begin
            ctrl_next[`PLC_KBD_ANY] = 1'b0;
            ctrl_next[`PLC_HUNT]    = 1'b0;
        end
    end
    // Resume decision on standby return
    wire [1:0] policy = ctrl_reg[`PLC_POLICY_HI:`PLC_POLICY_LO];
    logic      resume_on;
    always_comb begin
        case (policy)
            `POLICY_OFF:  resume_on = 1'b0;
            `POLICY_ON:   resume_on = 1'b1;
            `POLICY_PREV: resume_on = was_on_reg;
            default:      resume_on = ~last_reg[`LST_FLAG];
        endcase
    end

    wire hunt_wake = ctrl_reg[`PLC_HUNT] & s1_f & any_wake;
    wire pg_src    = grs_reg[`GRS_PG_SRC] ? s3_n_f : ~son_n_f;
    wire pg_next   = pg_src & (grs_reg[`GRS_PGIN_DIS] | sgood_f);
    wire [3:0] gpio_rst_next = {
        grs_reg[`GRS_GRP_A] ? pg_rst : bus_rst,
        grs_reg[`GRS_GRP9] ? s5_f : rsm_rst,
        grs_reg[`GRS_GRP8] ? s5_f : rsm_rst,
        grs_reg[`GRS_GRP7] ? s5_f : rsm_rst};

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg  <= SYNC_RST;
            sync2_reg  <= SYNC_RST;
            sync3_reg  <= SYNC_RST;
            filt_reg   <= SYNC_RST;
            filt_d_reg <= SYNC_RST;
        end else begin
            sync1_reg  <= pins;
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            filt_reg   <= (agree & sync2_reg) | (~agree & filt_reg);
            filt_d_reg <= filt_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_reg         <= acpi_wake_pkg::BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg    <= 32'h0000_0000;
        end else begin
            bus_reg         <= bus_next;
            waitrequest_reg <= (bus_next != acpi_wake_pkg::BUS_ACK);
            if (bus_reg == acpi_wake_pkg::BUS_IDLE && read_i) begin
                readdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end
    // Battery well: status, control and last-state flag
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_reg <= `RST_WAKE_EVT_STATUS;
            ctrl_reg   <= `RST_POWER_LOSS_CTRL;
            last_reg   <= `RST_LAST_STATE;
        end else begin
            status_reg <= status_next;
            ctrl_reg   <= ctrl_next;
            if (wr_last) begin
                last_reg <= wb & `LST_MASK;
            end
        end
    end
    // Standby well: cleared by resume reset as well
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            index_reg     <= `RST_KBD_WAKE_INDEX;
            grs_reg       <= `RST_GPIO_RST_SOURCE;
            wen_reg       <= `RST_WAKE_ENABLE;
            cap_ptr_reg   <= 4'h0;
            match_ptr_reg <= 4'h0;
        end else if (rsm_rst) begin
            index_reg     <= `RST_KBD_WAKE_INDEX;
            grs_reg       <= `RST_GPIO_RST_SOURCE;
            wen_reg       <= `RST_WAKE_ENABLE;
            cap_ptr_reg   <= 4'h0;
            match_ptr_reg <= 4'h0;
        end else begin
            if (wr_index) begin
                index_reg <= wb;
            end
            if (wr_grs) begin
                grs_reg <= wb & `GRS_MASK;
            end
            if (wr_wen) begin
                wen_reg <= wb & `WEN_MASK;
            end
            if (kbd_key_valid_i) begin
                cap_ptr_reg <= (cap_ptr_reg == `KEY_SLOTS - 4'h1) ? 4'h0
                                                                   : cap_ptr_reg + 4'h1;
            end
            match_ptr_reg <= match_ptr_next;
        end
    end
    // Key table has no reset; a software write to a valid slot beats any capture in the same cycle, whatever the capture's slot
    always_ff @(posedge mclk_i) begin
        if (wr_data && bus_slot[6]) begin
            key_mem[bus_slot[5:0]] <= wb;
        end else if (kbd_key_valid_i) begin
            key_mem[c_slot[5:0]] <= kbd_key_i;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            was_on_reg    <= 1'b0;
            pulse_cnt_reg <= 8'h00;
            gate_n_reg    <= 1'b1;
            power_button_out_n_n_reg   <= 1'b1;
            pg_reg        <= 1'b0;
            resume_on_reg <= 1'b0;
            gpio_rst_reg  <= 4'hf;
        end else begin
            if (standby_f && !standby_rise) begin
                was_on_reg <= s3_n_f;
            end
            if (hunt_wake) begin
                pulse_cnt_reg <= 8'(PULSE_CYCLES);
            end else if (pulse_cnt_reg != 8'h00) begin
                pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
            end
            // Button press passes through; hunting wake stretches a low pulse
            power_button_out_n_n_reg   <= power_button_in_n_f & ~hunt_wake & (pulse_cnt_reg <= 8'h01);
            gate_n_reg    <= ~ctrl_next[`PLC_GATE_EN];
            pg_reg        <= pg_next;
            resume_on_reg <= standby_rise & resume_on;
            gpio_rst_reg  <= gpio_rst_next;
        end
    end

    assign readdata_o           = readdata_reg;
    assign waitrequest_o        = waitrequest_reg;
    assign standby_gate_out_n_o = gate_n_reg;
    assign power_button_out_n_o = power_button_out_n_n_reg;
    assign power_good_out_o     = pg_reg;
    assign resume_power_on_o    = resume_on_reg;
    assign gpio_group_a_rst_o   = gpio_rst_reg[3];
    assign gpio_group9_rst_o    = gpio_rst_reg[2];
    assign gpio_group8_rst_o    = gpio_rst_reg[1];
    assign gpio_group7_rst_o    = gpio_rst_reg[0];

    property p_kbd_status;
        @(posedge mclk_i) disable iff (!reset_n_i) kbd_wake |=> status_reg[`STS_KBD];
    endproperty
    a_kbd_status: assert property (p_kbd_status) else $error("kbd wake not latched");
    property p_mouse_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
            (status_reg[`STS_MOUSE] && !rd_status) |=> status_reg[`STS_MOUSE];
    endproperty
    a_mouse_hold: assert property (p_mouse_hold) else $error("mouse flag lost");
    property p_read_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
            (rd_status && readdata_reg[`STS_PWR_BUTTON] && !power_button_in_fall)
            |=> !status_reg[`STS_PWR_BUTTON];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");
    property p_bus_answer;
        @(posedge mclk_i) disable iff (!reset_n_i)
            (bus_req && waitrequest_o && !acc) |=> !waitrequest_o ##1 waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing");
    property p_hunt_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
            (ctrl_reg[`PLC_HUNT] && any_wake) |=> !ctrl_reg[`PLC_HUNT];
    endproperty
    a_hunt_clear: assert property (p_hunt_clear) else $error("hunt bit stuck");
    property p_power_button_out_n;
        @(posedge mclk_i) disable iff (!reset_n_i)
            hunt_wake |=> !power_button_out_n_o [*2];
    endproperty
    a_power_button_out_n: assert property (p_power_button_out_n) else $error("no power button pulse");
    property p_policy_off;
        @(posedge mclk_i) disable iff (!reset_n_i)
            (standby_rise && policy == `POLICY_OFF) |=> !resume_power_on_o;
    endproperty
    a_policy_off: assert property (p_policy_off) else $error("resumed on off policy");
    property p_pg_gate;
        @(posedge mclk_i) disable iff (!reset_n_i)
            (!grs_reg[`GRS_PGIN_DIS] && !sgood_f) |=> !power_good_out_o;
    endproperty
    a_pg_gate: assert property (p_pg_gate) else $error("power good not gated");
    property p_bus_rst_ctrl;
        @(posedge mclk_i) disable iff (!reset_n_i)
            bus_rst |=> ctrl_reg[`PLC_KBD_ANY:`PLC_HUNT] == 2'h0;
    endproperty
    a_bus_rst_ctrl: assert property (p_bus_rst_ctrl) else $error("bus reset missed");
    property p_gate;
        @(posedge mclk_i) disable iff (!reset_n_i)
            ##1 standby_gate_out_n_o == !ctrl_reg[`PLC_GATE_EN];
    endproperty
    a_gate: assert property (p_gate) else $error("standby gate mismatch");
    property p_reserved;
        @(posedge mclk_i) disable iff (!reset_n_i)
            readdata_o[31:8] == 24'h00_0000 && status_reg[7:5] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule : acpi_wake_power_loss_ctrl

// ### rtl/acpi_wake_consts.svh
// Register indices, field positions, reset values and timing counts of the wake block
`ifndef ACPI_WAKE_CONSTS_SVH
`define ACPI_WAKE_CONSTS_SVH

`define IDX_WAKE_ENABLE      8'he0
`define IDX_KBD_WAKE_INDEX   8'he1
`define IDX_KBD_WAKE_DATA    8'he2
`define IDX_WAKE_EVT_STATUS  8'he3
`define IDX_POWER_LOSS_CTRL  8'he4
`define IDX_GPIO_RST_SOURCE  8'he5
`define IDX_LAST_STATE       8'he6

`define RST_KBD_WAKE_INDEX   8'h00
`define RST_WAKE_EVT_STATUS  8'h00
`define RST_POWER_LOSS_CTRL  8'h00
`define RST_GPIO_RST_SOURCE  8'h02
`define RST_WAKE_ENABLE      8'h00
`define RST_LAST_STATE       8'h10

`define WEN_ANY_CHAR         0
`define WEN_KBD              1
`define WEN_MOUSE            2
`define WEN_MASK             8'h07

`define STS_STANDBY          4
`define STS_THERMAL          3
`define STS_PWR_BUTTON       2
`define STS_MOUSE            1
`define STS_KBD              0
`define STS_MASK             8'h1f

`define PLC_POLICY_HI        6
`define PLC_POLICY_LO        5
`define PLC_GATE_EN          4
`define PLC_KBD_ANY          3
`define PLC_HUNT             2
`define PLC_MASK             8'h7c

`define GRS_GRP_A            7
`define GRS_GRP9             6
`define GRS_GRP8             5
`define GRS_GRP7             4
`define GRS_PG_SRC           1
`define GRS_PGIN_DIS         0
`define GRS_MASK             8'hf3

`define LST_FLAG             4
`define LST_MASK             8'h10

`define POLICY_OFF           2'h0
`define POLICY_ON            2'h1
`define POLICY_PREV          2'h2
`define POLICY_USER          2'h3

`define CAPTURE_BASE         8'h10
`define KEY_SLOTS            4'hf

`define POWER_BUTTON_OUT_N_PULSE_CYCLES   8

`endif

// ### rtl/acpi_wake_pkg.sv
// Types shared by the wake and power-loss block
package acpi_wake_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;
    typedef logic [7:0] key_byte_t;
endpackage : acpi_wake_pkg

// ### test/acpi_wake_partner.sv
// Keyboard, mouse and platform pin model facing the wake block
module acpi_wake_partner (
    input  wire logic  mclk_i,
    output logic       key_valid_o = 1'b0,
    output logic [7:0] key_o = 8'h00,
    output logic       mouse_o = 1'b0,
    output logic [9:0] pin_o = 10'h396
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic send_key(input logic [7:0] k);
        @(posedge mclk_i);
        key_valid_o <= 1'b1;
        key_o       <= k;
        @(posedge mclk_i);
        key_valid_o <= 1'b0;
        key_o       <= ~k;  // Stale byte changes so it never matches by luck
    endtask : send_key
    task automatic mouse_evt();
        @(posedge mclk_i);
        mouse_o <= 1'b1;
        @(posedge mclk_i);
        mouse_o <= 1'b0;
    endtask : mouse_evt
    task automatic set_pin(input int n, input logic v);
        @(posedge mclk_i);
        pin_o[n] <= v;
        repeat (8) @(posedge mclk_i);  // Pin filters need about five edges
    endtask : set_pin
endmodule : acpi_wake_partner

// ### test/test_acpi_wake_power_loss_ctrl.sv
// Self-checking bench of the wake and power-loss block
module test_acpi_wake_power_loss_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 2;
    logic        clk;
    logic        rst_n;
    logic [7:0]  address;
    logic        rd;
    logic        wr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        wreq;
    logic        kv;
    logic        ms;
    logic [7:0]  kb;
    logic [9:0]  pin;
    logic        gate_n;
    logic        btn_n;
    logic        pg;
    logic        pon;
    logic [3:0]  grp;
    logic [31:0] v;
    logic [7:0]  km [256];
    logic [7:0]  sent [$];
    int          base [3] = '{0, 'h30, 'h40};
    int          bad_count = 0;
    int          cmp_count = 0;
    int          seed;
    int          pulses;
    int          lows;
    int          p;
    acpi_wake_power_loss_ctrl #(.PULSE_CYCLES(PC)) u_acpi_wake_power_loss_ctrl (
        .mclk_i(clk), .reset_n_i(rst_n), .address_i(address), .read_i(rd),
        .write_i(wr), .writedata_i(wdat), .byteenable_i(4'h1), .readdata_o(rdat),
        .waitrequest_o(wreq), .kbd_key_valid_i(kv), .kbd_key_i(kb), .mouse_wake_evt_i(ms),
        .thermal_evt_i(pin[0]), .power_button_in_n_i(pin[1]), .standby_supply_ok_i(pin[2]),
        .sleep_s1_i(pin[3]), .sleep_s3_n_i(pin[4]), .sleep_s5_i(pin[5]),
        .supply_on_n_i(pin[6]), .supply_good_in_i(pin[7]), .resume_reset_n_i(pin[8]),
        .bus_reset_n_i(pin[9]), .standby_gate_out_n_o(gate_n), .power_button_out_n_o(btn_n),
        .power_good_out_o(pg), .resume_power_on_o(pon), .gpio_group_a_rst_o(grp[3]),
        .gpio_group9_rst_o(grp[2]), .gpio_group8_rst_o(grp[1]), .gpio_group7_rst_o(grp[0]));
    acpi_wake_partner u_p (.mclk_i(clk), .key_valid_o(kv), .key_o(kb), .mouse_o(ms),
        .pin_o(pin));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pon === 1'b1) pulses++;
        if (btn_n === 1'b0) lows++;
    end
    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Avalon cycle: hold everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, d, output logic [31:0] dq);
        int n;
        n = 0;
        @(posedge clk);
        rd      <= ~w;
        wr      <= w;
        address <= a;
        wdat    <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        dq = rdat;
        if (n >= 40) chk("wait", 1'b1, 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wreg(input logic [7:0] a, d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wreg
    task automatic rreg(input string nm, input logic [7:0] a, e);
        logic [31:0] x;
        bus(1'b0, a, 8'h00, x);
        chk(nm, x, {24'h0, e});
    endtask : rreg
    function automatic logic [7:0] kidx(int i);
        return 8'(base[i / 15] + i % 15);
    endfunction : kidx
    initial begin
        #1000000;
        bad_count++;
        close_out();
    end
    initial begin
        seed = 32'hbe41;
        {rst_n, rd, wr, address, wdat} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
        rreg("idx", 8'he1, 8'h00);
        rreg("sts", 8'he3, 8'h00);
        rreg("plc", 8'he4, 8'h00);
        rreg("grs", 8'he5, 8'h02);
        wreg(8'h7f, 8'h55);
        rreg("unmapped", 8'h7f, 8'h00);
        wreg(8'he4, 8'hff);
        rreg("plc", 8'he4, 8'h7c);
        chk("gate", gate_n, 1'b0);
        wreg(8'he5, 8'hff);
        rreg("grs", 8'he5, 8'hf3);
        u_p.set_pin(5, 1'b1);
        chk("grp", grp, 4'h7);
        wreg(8'he5, 8'h03);
        u_p.set_pin(5, 1'b0);
        chk("grp", grp, 4'h0);
        u_p.set_pin(9, 1'b0);
        chk("grp", grp, 4'h8);
        u_p.set_pin(9, 1'b1);
        rreg("plc", 8'he4, 8'h70);
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wreg(8'he5, {6'h00, v[1:0]});
            u_p.set_pin(4, v[2]);
            u_p.set_pin(6, v[3]);
            u_p.set_pin(7, v[4]);
            chk("pg", pg, (v[1] ? v[2] : ~v[3]) & (v[0] | v[4]));
        end
        u_p.set_pin(4, 1'b1);
        u_p.set_pin(6, 1'b0);
        wreg(8'he5, 8'h02);
        wreg(8'he4, 8'h10);
        u_p.set_pin(7, 1'b0);
        rreg("plc", 8'he4, 8'h00);
        u_p.set_pin(7, 1'b1);
        for (int i = 0; i < 45; i++) begin
            km[kidx(i)] = 8'($random(seed));
            wreg(8'he1, kidx(i));
            wreg(8'he2, km[kidx(i)]);
        end
        for (int i = 0; i < 45; i++) begin
            wreg(8'he1, kidx(i));
            rreg("key", 8'he2, km[kidx(i)]);
        end
        for (int j = 0; j < 3; j++) begin
            sent.push_back(8'($random(seed)));
            u_p.send_key(sent[j]);
        end
        rreg("sts", 8'he3, 8'h00);
        for (int j = 0; j < 3; j++) begin
            wreg(8'he1, 8'h10 + 8'(j));
            rreg("cap", 8'he2, sent[j]);
        end
        wreg(8'he1, 8'h00);
        wreg(8'he2, 8'ha5);
        wreg(8'he1, 8'h01);
        wreg(8'he2, 8'h00);
        wreg(8'he0, 8'h02);
        u_p.send_key(8'h5a);
        rreg("sts", 8'he3, 8'h00);
        wreg(8'he4, 8'h08);
        u_p.send_key(8'h5a);
        rreg("sts", 8'he3, 8'h01);
        rreg("sts", 8'he3, 8'h00);
        wreg(8'he4, 8'h00);
        u_p.send_key(8'ha5);
        rreg("sts", 8'he3, 8'h01);
        wreg(8'he0, 8'h07);
        u_p.send_key(8'h3c);
        u_p.mouse_evt();
        rreg("sts", 8'he3, 8'h03);
        u_p.set_pin(0, 1'b1);
        rreg("sts", 8'he3, 8'h08);
        u_p.set_pin(1, 1'b0);
        rreg("sts", 8'he3, 8'h04);
        u_p.set_pin(1, 1'b1);
        u_p.set_pin(2, 1'b0);
        u_p.set_pin(2, 1'b1);
        rreg("sts", 8'he3, 8'h10);
        wreg(8'he4, 8'h04);
        u_p.set_pin(3, 1'b1);
        lows = 0;
        u_p.mouse_evt();
        repeat (8) @(posedge clk);
        chk("pulse", lows, PC);
        rreg("plc", 8'he4, 8'h00);
        rreg("sts", 8'he3, 8'h02);
        u_p.set_pin(3, 1'b0);
        for (int i = 0; i < 5; i++) begin
            p = (i < 4) ? i : 3;
            wreg(8'he6, (i == 4) ? 8'h10 : 8'h00);
            wreg(8'he4, 8'(p << 5));
            pulses = 0;
            u_p.set_pin(2, 1'b0);
            u_p.set_pin(2, 1'b1);
            chk("resume", pulses, (p == 1 || p == 2 || i == 3) ? 1 : 0);
        end
        wreg(8'he5, 8'hf2);
        u_p.set_pin(8, 1'b0);
        u_p.set_pin(8, 1'b1);
        rreg("sts", 8'he3, 8'h10);
        rreg("grs", 8'he5, 8'h02);
        // Fifteen captures fill 10h..1Eh, the sixteenth wraps to 10h
        for (int j = 0; j < 16; j++) begin
            sent.push_back(8'($random(seed)));
            u_p.send_key(sent[j + 3]);
        end
        wreg(8'he1, 8'h1e);
        rreg("cap_last", 8'he2, sent[17]);
        wreg(8'he1, 8'h10);
        rreg("cap_wrap", 8'he2, sent[18]);
        close_out();
    end
endmodule : test_acpi_wake_power_loss_ctrl
